// [slp_pkg.sv]
// Constants and carrier types for the SSI linear position slave.
`default_nettype none
package slp_pkg;
  // Serial word layout.
  localparam int WORD_BITS    = 25;
  localparam int POS_BITS_DEF = 20;
  localparam int CNT_BITS     = 5;
  // Reset values.
  localparam logic [WORD_BITS-1:0] WORD_RST = 25'h0000000;
  localparam logic                 IDLE_LVL = 1'b1;
  // Timing, in nanoseconds, and derived cycle counts.
  localparam int CLK_NS       = 10;
  localparam int MONO_NS      = 12000;
  localparam int ZERO_HOLD_NS = 100000;
  localparam int MONO_CYC      = (MONO_NS / CLK_NS) < 1 ? 1 : (MONO_NS / CLK_NS);
  localparam int ZERO_HOLD_CYC = (ZERO_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MONO_CW       = $clog2(MONO_CYC + 1);

  // One reading from the sensing front end, same clock as the block.
  typedef struct packed {
    logic                    valid;
    logic [POS_BITS_DEF-1:0] count;
  } slp_scale_s;

  // Pins from the outside world, asynchronous to the block clock.
  typedef struct packed {
    logic zero_set;
    logic count_dir;
  } slp_pins_s;
endpackage
`default_nettype wire

// [slp_ssi_slave.sv]
// SSI slave that serialises a Gray-coded absolute linear position.
//
// Summary of operation
// [RULE_01] First falling clock edge latches the position.
// [RULE_02] Next rising edge starts sending, MSB first.
// [RULE_03] One bit per rising edge; n+1 edges total.
// [RULE_04] Final rising edge ends frame, starts monoflop.
// [RULE_05] Surplus clocks send logic low.
// [RULE_06] After monoflop interval, data high, frame accepted.
// [RULE_07] Always 25 bits, LSB on final clock.
// [RULE_08] Unused upper bits sent as leading zeros.
// [RULE_09] Position width 16, 17, 19 or 20 bits.
// [RULE_10] Position field is Gray coded.
// [RULE_11] Master clock between 100 kHz and 1.5 MHz. The behavioural master uses a 30 ns period.
// [RULE_12] Master pause over 30 us between bursts. The behavioural master pauses 1000 ns.
// [RULE_13] Zero is sent until first valid reading.
// [RULE_14] Fault freezes last valid position.
// [RULE_15] Error output high while sensing error active.
// [RULE_16] Value is raw count in resolution units.
// [RULE_17] Zero-set held 100 us then released zeroes.
// [RULE_18] Direction input reverses counting sense.
// [RULE_19] Set direction first, then zero-set.
// [RULE_20] Master holds clock high between frames.
// [RULE_21] Data low, clocks ignored during monoflop.
`timescale 1ns/1ps
`default_nettype none
module slp_ssi_slave #(
  parameter int POS_BITS      = slp_pkg::POS_BITS_DEF,
  parameter int ZERO_HOLD_CYC = slp_pkg::ZERO_HOLD_CYC,
  parameter int MONO_CYC      = slp_pkg::MONO_CYC
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ssi_clk,
  input  wire slp_pkg::slp_scale_s scale,
  input  wire slp_pkg::slp_pins_s  pins,
  output logic                    ssi_data,
  output logic                    err_led
);
  localparam int WB = slp_pkg::WORD_BITS;
  localparam int ZCW = $clog2(ZERO_HOLD_CYC + 1);
  localparam int MCW = $clog2(MONO_CYC + 1);
  localparam logic [slp_pkg::CNT_BITS-1:0] LAST_IDX = slp_pkg::CNT_BITS'(WB - 1);
  localparam logic [slp_pkg::CNT_BITS-1:0] WORD_CNT = slp_pkg::CNT_BITS'(WB);

  if (!(POS_BITS == 16 || POS_BITS == 17 || POS_BITS == 19 || POS_BITS == 20)) begin : g_bad_pos
    $error("POS_BITS must be 16, 17, 19 or 20");
  end
  if (MONO_CYC < 1 || ZERO_HOLD_CYC < 1) begin : g_bad_time
    $error("MONO_CYC and ZERO_HOLD_CYC must be at least 1");
  end

  function automatic logic [WB-1:0] to_gray(input logic [WB-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // ---------------- Block clock domain ----------------

  logic                zs_q1_r;
  logic                zs_q2_r;
  logic                dir_q1_r;
  logic                dir_q2_r;
  logic [ZCW-1:0]      zero_cnt_r;
  logic                zero_fire;
  logic [POS_BITS-1:0] raw_r;
  logic                got_valid_r;
  logic [POS_BITS-1:0] offset_r;
  logic [POS_BITS-1:0] pos_bin;
  logic [WB-1:0]       gray_r;
  logic                end_s1_r;
  logic                end_s2_r;
  logic                end_s3_r;
  logic                end_seen;
  logic [MCW-1:0]      mono_cnt_r;
  logic                done_tgl_r;

  // Link side registers and frame decodes.
  logic                frame_tgl_l;
  logic [WB-1:0]       shift_r;
  logic                seen_l;
  logic [slp_pkg::CNT_BITS-1:0] cnt_l;
  logic                data_l;
  logic                end_tgl_l;
  logic                in_frame;
  logic                fresh;

  // Pins come from outside; two flops before any logic reads them.
  always_ff @(posedge clock) begin
    if (rst) begin
      zs_q1_r  <= 1'b0;
      zs_q2_r  <= 1'b0;
      dir_q1_r <= 1'b0;
      dir_q2_r <= 1'b0;
    end else begin
      zs_q1_r  <= pins.zero_set;
      zs_q2_r  <= zs_q1_r;
      dir_q1_r <= pins.count_dir;
      dir_q2_r <= dir_q1_r;
    end
  end

  // [RULE_17] Zero-set hold timing.
  always_ff @(posedge clock) begin
    if (rst || !zs_q2_r) begin
      zero_cnt_r <= '0;
    end else if (zero_cnt_r != ZCW'(ZERO_HOLD_CYC)) begin
      zero_cnt_r <= zero_cnt_r + 1'b1;
    end
  end
  assign zero_fire = !zs_q2_r && (zero_cnt_r == ZCW'(ZERO_HOLD_CYC));

  // [RULE_14] Freeze on fault.
  // Only valid readings update the raw count, so a fault keeps the last one.
  always_ff @(posedge clock) begin
    if (rst) begin
      raw_r       <= '0;
      got_valid_r <= 1'b0;
    end else if (scale.valid) begin
      raw_r       <= scale.count[POS_BITS-1:0];
      got_valid_r <= 1'b1;
    end
  end

  // [RULE_17] Reference taken on release.
  // The current reading becomes the origin, so the position reads zero here.
  always_ff @(posedge clock) begin
    if (rst) begin
      offset_r <= '0;
    end else if (zero_fire) begin
      offset_r <= raw_r;
    end
  end

  // [RULE_18] Counting sense select.
  // [RULE_16] Raw resolution counts.
  // A direction change moves the origin's meaning; a fresh zero-set is needed after it.
  always_comb begin
    if (dir_q2_r) begin
      pos_bin = offset_r - raw_r;
    end else begin
      pos_bin = raw_r - offset_r;
    end
  end

  // [RULE_10] Gray encoding.
  // [RULE_13] Zero before first reading.
  // [RULE_08] Leading zero bits.
  // [RULE_09] Field width select.
  always_ff @(posedge clock) begin
    if (rst || !got_valid_r) begin
      gray_r <= slp_pkg::WORD_RST;
    end else begin
      gray_r <= to_gray({{(WB - POS_BITS){1'b0}}, pos_bin});
    end
  end

  // [RULE_15] Error indicator.
  always_ff @(posedge clock) begin
    if (rst) begin
      err_led <= 1'b1;
    end else begin
      err_led <= !scale.valid;
    end
  end

  // Frame end crosses from the link as a toggle.
  always_ff @(posedge clock) begin
    if (rst) begin
      end_s1_r <= 1'b0;
      end_s2_r <= 1'b0;
      end_s3_r <= 1'b0;
    end else begin
      end_s1_r <= end_tgl_l;
      end_s2_r <= end_s1_r;
      end_s3_r <= end_s2_r;
    end
  end
  assign end_seen = end_s2_r ^ end_s3_r;

  // [RULE_06] Monoflop interval.
  // Timed on the block clock because the master clock stops after a frame.
  always_ff @(posedge clock) begin
    if (rst) begin
      mono_cnt_r <= '0;
      done_tgl_r <= 1'b0;
    end else if (end_seen) begin
      mono_cnt_r <= MCW'(MONO_CYC);
    end else if (mono_cnt_r != '0) begin
      mono_cnt_r <= mono_cnt_r - 1'b1;
      if (mono_cnt_r == MCW'(1)) begin
        done_tgl_r <= ~done_tgl_r;
      end
    end
  end

  // ---------------- Link clock domain ----------------

  // The two toggles differ from capture until the monoflop ends. The done toggle
  // only moves while the master clock is idle, so the link reads it directly.
  assign in_frame = frame_tgl_l ^ done_tgl_r;
  assign fresh    = seen_l != frame_tgl_l;

  // [RULE_01] Capture on first falling edge.
  // The captured word is Gray coded, so a move of one count changes one bit.
  always_ff @(negedge ssi_clk or posedge rst) begin
    if (rst) begin
      frame_tgl_l <= 1'b0;
      shift_r     <= slp_pkg::WORD_RST;
    end else if (!in_frame) begin
      shift_r     <= gray_r;
      frame_tgl_l <= ~frame_tgl_l;
    end
  end

  // [RULE_02] MSB on first rising edge.
  // [RULE_03] One bit per rising edge.
  // [RULE_07] LSB on 25th edge.
  // [RULE_05] Surplus clocks send zero.
  // [RULE_04] Frame end on final edge.
  // A master that stops early leaves the frame open; the next burst keeps shifting.
  always_ff @(posedge ssi_clk or posedge rst) begin
    if (rst) begin
      seen_l    <= 1'b0;
      cnt_l     <= '0;
      data_l    <= 1'b0;
      end_tgl_l <= 1'b0;
    end else if (in_frame) begin
      if (fresh) begin
        seen_l <= frame_tgl_l;
        cnt_l  <= 5'h01;
        data_l <= shift_r[WB-1];
      end else if (cnt_l < WORD_CNT) begin
        data_l <= shift_r[LAST_IDX - cnt_l];
        cnt_l  <= cnt_l + 5'h01;
      end else begin
        data_l <= 1'b0;
        if (cnt_l == WORD_CNT) begin
          end_tgl_l <= ~end_tgl_l;
          cnt_l     <= cnt_l + 5'h01;
        end
      end
    end
  end

  // [RULE_21] Line low during monoflop.
  // [RULE_20] Idle line high between frames.
  assign ssi_data = (in_frame && !fresh) ? data_l : slp_pkg::IDLE_LVL;

  // ---------------- Checks ----------------

  a_msb_first: assert property (@(posedge ssi_clk) disable iff (rst) // [RULE_02]
    (in_frame && fresh) |=> (data_l == $past(shift_r[WB-1])) && (cnt_l == 5'h01))
    else $error("first bit is not the MSB of the captured word");

  a_word_stable: assert property (@(posedge ssi_clk) disable iff (rst) // [RULE_01]
    (in_frame && !fresh) |-> $stable(shift_r))
    else $error("captured word changed during a frame");

  a_lsb_last: assert property (@(posedge ssi_clk) disable iff (rst) // [RULE_07]
    (in_frame && !fresh && cnt_l == 5'h18) |=> (data_l == $past(shift_r[0])))
    else $error("LSB not sent on the 25th rising edge");

  a_surplus_zero: assert property (@(posedge ssi_clk) disable iff (rst) // [RULE_05]
    (in_frame && !fresh && cnt_l >= WORD_CNT) |=> (data_l == 1'b0))
    else $error("surplus clock did not send zero");

  a_end_toggle: assert property (@(posedge ssi_clk) disable iff (rst) // [RULE_04]
    (in_frame && !fresh && cnt_l == WORD_CNT) |=> (end_tgl_l != $past(end_tgl_l)))
    else $error("frame end not flagged on the final rising edge");

  a_mono_length: assert property (@(posedge clock) disable iff (rst) // [RULE_06]
    end_seen |=> (mono_cnt_r == MCW'(MONO_CYC)) ##1 (mono_cnt_r == MCW'(MONO_CYC - 1)))
    else $error("monoflop interval not started at its full length");

  a_mono_release: assert property (@(posedge clock) disable iff (rst) // [RULE_06]
    (mono_cnt_r == MCW'(1) && !end_seen) |=> (done_tgl_r != $past(done_tgl_r)))
    else $error("monoflop expiry did not release the line");

  a_zero_start: assert property (@(posedge clock) disable iff (rst) // [RULE_13]
    !got_valid_r |=> (gray_r == slp_pkg::WORD_RST))
    else $error("nonzero word sent before the first valid reading");

  a_upper_zero: assert property (@(posedge clock) disable iff (rst) // [RULE_08]
    (gray_r >> POS_BITS) == '0)
    else $error("bits above the position field are not zero");

  a_gray_code: assert property (@(posedge clock) disable iff (rst) // [RULE_10]
    got_valid_r |=> (gray_r == to_gray({{(WB - POS_BITS){1'b0}}, $past(pos_bin)})))
    else $error("position field is not Gray coded");

  a_fault_freeze: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
    !scale.valid |=> $stable(raw_r))
    else $error("position moved during a fault");

  a_error_led: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
    ##1 (err_led == !$past(scale.valid)))
    else $error("error indicator does not follow the sensing state");

  a_zero_set: assert property (@(posedge clock) disable iff (rst) // [RULE_17]
    zero_fire |=> (offset_r == $past(raw_r)))
    else $error("zero-set did not take the current reading as origin");

  a_short_hold: assert property (@(posedge clock) disable iff (rst) // [RULE_17]
    ($fell(zs_q2_r) && zero_cnt_r != ZCW'(ZERO_HOLD_CYC)) |=> $stable(offset_r))
    else $error("zero-set taken after a short hold");

  c_full_frame: cover property (@(posedge ssi_clk) disable iff (rst)
    in_frame && cnt_l == WORD_CNT);
  c_surplus: cover property (@(posedge ssi_clk) disable iff (rst)
    in_frame && cnt_l > WORD_CNT);
  c_zero_set: cover property (@(posedge clock) disable iff (rst) zero_fire);
  c_fault: cover property (@(posedge clock) disable iff (rst)
    got_valid_r && !scale.valid);
endmodule
`default_nettype wire

// [slp_ssi_master.sv]
// Behavioural SSI master that clocks frames out of the position slave.
`timescale 1ns/1ps
`default_nettype none
module slp_ssi_master #(
  parameter real HALF = 15.0
) (
  output logic     ssi_clk,
  input  wire logic ssi_data
);
  initial ssi_clk = 1'b1;

  task automatic run(input int n, output logic [31:0] word);
    word = '0;
    // inter_frame_pause.
    // Scaled down with the monoflop so the run stays short, still well above it.
    #1000.0;
    #3.7;
    ssi_clk = 1'b0;
    // one falling, then n rising edges.
    for (int i = 0; i < n; i++) begin
      #HALF ssi_clk = 1'b1;
      #(HALF - 1.0) word = {word[30:0], ssi_data};
      if (i < n - 1) begin
        #1.0 ssi_clk = 1'b0;
      end
    end
    #1.0;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the SSI linear position slave.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PB = 16;
  localparam int ZH = 20;
  localparam int MC = 30;
  logic                clock;
  logic                rst;
  wire logic           ssi_clk;
  logic                ssi_data;
  logic                err_led;
  slp_pkg::slp_scale_s scale;
  slp_pkg::slp_pins_s  pins;
  int                  mismatches;
  int                  cmp_count;
  int                  cycles;
  logic [31:0]         w;

  slp_ssi_slave #(
    .POS_BITS      (PB),
    .ZERO_HOLD_CYC (ZH),
    .MONO_CYC      (MC)
  ) slp_ssi_slave_inst (
    .clock    (clock),
    .rst      (rst),
    .ssi_clk  (ssi_clk),
    .scale    (scale),
    .pins     (pins),
    .ssi_data (ssi_data),
    .err_led  (err_led)
  );

  slp_ssi_master slp_ssi_master_inst (
    .ssi_clk  (ssi_clk),
    .ssi_data (ssi_data)
  );

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [24:0] gw(input logic [15:0] v);
    return {9'h000, v ^ (v >> 1)};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic put(input logic v, input logic [19:0] c);
    @(posedge clock);
    scale.valid <= v;
    scale.count <= c;
    cyc(4);
  endtask

  task automatic zs(input int n);
    @(posedge clock);
    pins.zero_set <= 1'b1;
    cyc(n);
    pins.zero_set <= 1'b0;
    cyc(6);
  endtask

  // Three surplus clocks per frame, then the monoflop low and the return high.
  task automatic frm(input logic [24:0] exp);
    slp_ssi_master_inst.run(28, w);
    check(w[27:3], exp);
    check({22'h000000, w[2:0]}, 25'h0000000);
    @(posedge clock);
    check({24'h000000, ssi_data}, 25'h0000000);
    cyc(MC + 10);
    check({24'h000000, ssi_data}, 25'h0000001);
  endtask

  task automatic s_boot();
    put(1'b0, 20'h01234);
    check({24'h000000, err_led}, 25'h0000001);
    frm(25'h0000000);
  endtask

  task automatic s_fault();
    put(1'b1, 20'hFABCD);
    check({24'h000000, err_led}, 25'h0000000);
    frm(gw(16'hABCD));
    put(1'b0, 20'h00005);
    check({24'h000000, err_led}, 25'h0000001);
    frm(gw(16'hABCD));
  endtask

  // A move after the capturing edge must not reach the word in flight.
  task automatic s_latch();
    put(1'b1, 20'h00011);
    fork
      frm(gw(16'h0011));
      begin
        #1300;
        @(posedge clock);
        scale.count <= 20'h00022;
      end
    join
    frm(gw(16'h0022));
  endtask

  task automatic s_zero();
    zs(ZH / 2);
    frm(gw(16'h0022));
    zs(ZH + 4);
    frm(25'h0000000);
    put(1'b1, 20'h00025);
    frm(gw(16'h0003));
    @(posedge clock);
    pins.count_dir <= 1'b1;
    cyc(4);
    zs(ZH + 4);
    put(1'b1, 20'h00022);
    frm(gw(16'h0003));
    put(1'b1, 20'h00026);
    frm(gw(16'hFFFF));
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    rst = 1'b1;
    scale = '0;
    pins = '0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    check({24'h000000, ssi_data}, 25'h0000001);
    s_boot();
    s_fault();
    s_latch();
    s_zero();
    results();
  end
endmodule
`default_nettype wire
